// File: rtl/tcr_baud_gen.sv
// Bit-rate tick generator for the serial link
`timescale 1ns/1ps
`include "tcr_defines.svh"

module tcr_baud_gen
    import tcr_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   highRate,
    output logic        bitTick
);

    localparam logic [CNT_W-1:0] CYC_HIGH = CNT_W'(`TCR_BIT_CYC_HIGH);
    localparam logic [CNT_W-1:0] CYC_LOW  = CNT_W'(`TCR_BIT_CYC_LOW);

    if ((1 << CNT_W) <= `TCR_BIT_CYC_LOW) begin : g_chk
        $error("CNT_W too small for the low link rate");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] period;
    logic             tick_d;
    logic             tick_q;

    assign period = highRate ? CYC_HIGH : CYC_LOW;
    assign tick_d = (cnt_q >= period - CNT_W'(1));
    assign cnt_d  = tick_d ? '0 : cnt_q + CNT_W'(1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign bitTick = tick_q;

endmodule : tcr_baud_gen

// File: rtl/tcr_config_regs.sv
// Configuration registers 0x00 to 0x04 of the dual-line transceiver
`timescale 1ns/1ps
`include "tcr_defines.svh"

module tcr_config_regs
    import tcr_pkg::*;
#(
    parameter int BAUD_CNT_W = 10
) (
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   spiCsN,
    input  wire logic   spiSclk,
    input  wire logic   spiMosi,
    output logic        spiMiso,
    output logic        spiMisoOe,
    output logic [3:0]  type1OndemandSize,
    output logic        type1Legacy,
    output logic        type1Reserved,
    output logic [3:0]  type2OndemandSize,
    output logic        type2Reserved,
    output logic [3:0]  expectedReadOctets,
    output logic [2:0]  undervoltageThreshold,
    output logic        baudSelect,
    output logic        linkBitTick,
    output logic        comparatorReferenceSelect,
    output logic        auxRegulatorPowerdown,
    output logic        transparentUartMode,
    output logic        singleOctetUartMode,
    output logic        standardIoModeRequest,
    output logic [2:0]  primaryOvercurrentThreshold,
    output logic        primaryHighSideSwitchEnable,
    output logic        primaryLowSideSwitchEnable,
    output logic        auxControlPinEnable,
    output logic        levelChangeIrqEnable,
    output logic        digitalIoModeRequest,
    output logic [2:0]  secondaryOvercurrentThreshold,
    output logic        secondaryHighSideSwitchEnable,
    output logic        secondaryLowSideSwitchEnable,
    input  wire logic   secondaryLine,
    output logic        levelChangeIrq,
    input  wire logic [3:0] bufferFillCount,
    output logic        bufferFillCountLoad,
    output logic [3:0]  bufferFillCountValue,
    output logic        declineResponse,
    output logic        sendResponseNow
);

    if (BAUD_CNT_W < 9) begin : g_chk
        $error("BAUD_CNT_W too small for the link rate divider");
    end

    // ----------------------------------------
    // On-demand size decoding
    // ----------------------------------------
    // Returns octet count; legacy code for type 1 reports zero
    function automatic logic [3:0] odOctets(input logic [1:0] code, input logic isType1);
        logic [3:0] n;
        n = 4'h0;
        case (tcr_od_e'(code))
            TCR_OD_CODE0: n = isType1 ? 4'h0 : 4'h1;
            TCR_OD_CODE1: n = 4'h2;
            TCR_OD_CODE2: n = 4'h8;
            default:      n = 4'h0;
        endcase
        return n;
    endfunction : odOctets

    // ----------------------------------------
    // Serial access port
    // ----------------------------------------
    logic      hdrValid;
    tcr_byte_t hdrByte;
    logic      dataValid;
    tcr_byte_t dataByte;
    tcr_byte_t rdData;

    tcr_spi_slave #(
        .DATA_W     (8)
    ) u_spi (
        .clk        (clk),
        .resetn     (resetn),
        .spiCsN     (spiCsN),
        .spiSclk    (spiSclk),
        .spiMosi    (spiMosi),
        .spiMiso    (spiMiso),
        .spiMisoOe  (spiMisoOe),
        .txByte     (rdData),
        .hdrValid   (hdrValid),
        .hdrByte    (hdrByte),
        .dataValid  (dataValid),
        .dataByte   (dataByte)
    );

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    tcr_byte_t seq_q;
    tcr_byte_t cfg_q;
    tcr_byte_t pctl_q;
    tcr_byte_t sctl_q;
    tcr_addr_t addr_q;
    logic      isWrite_q;
    logic      lineLevel_q;
    logic      irq_q;
    logic      decline_q;
    logic      send_q;
    logic      cntLoad_q;
    logic [3:0] cntValue_q;

    // Header bit 7 high marks a write; bits 6:0 give the address
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q    <= '0;
            isWrite_q <= 1'b0;
        end else if (hdrValid) begin
            addr_q    <= hdrByte[6:0];
            isWrite_q <= hdrByte[7];
        end
    end

    logic wrStrobe;
    logic wrSeq;
    logic wrCfg;
    logic wrPctl;
    logic wrSctl;
    logic wrLink;

    assign wrStrobe = dataValid && isWrite_q;

    // Address decode for writes; unmapped addresses are ignored
    always_comb begin
        wrSeq  = 1'b0;
        wrCfg  = 1'b0;
        wrPctl = 1'b0;
        wrSctl = 1'b0;
        wrLink = 1'b0;
        if (!wrStrobe) begin
            wrSeq = 1'b0;
        end else if (addr_q == `TCR_ADDR_SEQ) begin
            wrSeq = 1'b1;
        end else if (addr_q == `TCR_ADDR_CFG) begin
            wrCfg = 1'b1;
        end else if (addr_q == `TCR_ADDR_PCTL) begin
            wrPctl = 1'b1;
        end else if (addr_q == `TCR_ADDR_SCTL) begin
            wrSctl = 1'b1;
        end else if (addr_q == `TCR_ADDR_LINK) begin
            wrLink = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seq_q  <= `TCR_RST_SEQ;
            cfg_q  <= `TCR_RST_CFG;
            pctl_q <= `TCR_RST_PCTL;
            sctl_q <= `TCR_RST_SCTL;
        end else begin
            if (wrSeq) begin
                seq_q <= dataByte;
            end
            if (wrCfg) begin
                cfg_q <= dataByte & `TCR_CFG_RD_MASK;
            end
            if (wrPctl) begin
                pctl_q <= dataByte;
            end
            if (wrSctl) begin
                sctl_q <= dataByte;
            end
        end
    end

    // Link command bits are pulses and never stored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            decline_q  <= 1'b0;
            send_q     <= 1'b0;
            cntLoad_q  <= 1'b0;
            cntValue_q <= '0;
        end else begin
            decline_q <= wrLink && dataByte[`TCR_LINK_DECLINE];
            send_q    <= wrLink && dataByte[`TCR_LINK_SEND];
            cntLoad_q <= wrLink;
            if (wrLink) begin
                cntValue_q <= dataByte[`TCR_LINK_CNT_HI:`TCR_LINK_CNT_LO];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [6:0] rdAddr;
    assign rdAddr = hdrByte[6:0];

    // Decode from the captured header, ready for load next cycle
    always_comb begin
        rdData = 8'h00;
        if (rdAddr == `TCR_ADDR_SEQ) begin
            rdData = seq_q;
        end else if (rdAddr == `TCR_ADDR_CFG) begin
            rdData = cfg_q & `TCR_CFG_RD_MASK;
        end else if (rdAddr == `TCR_ADDR_PCTL) begin
            rdData = pctl_q;
        end else if (rdAddr == `TCR_ADDR_SCTL) begin
            rdData = sctl_q;
        end else if (rdAddr == `TCR_ADDR_LINK) begin
            // Write-only command bits and top bits read as zero
            rdData = {2'b00, bufferFillCount, 2'b00};
        end
    end

    // ----------------------------------------
    // Secondary line level-change interrupt
    // ----------------------------------------
    // Sampled level; any edge, the first after reset too, is reported while enabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lineLevel_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            lineLevel_q <= secondaryLine;
            irq_q       <= sctl_q[`TCR_CTL_MODE3] && (secondaryLine != lineLevel_q);
        end
    end

    // ----------------------------------------
    // Link rate
    // ----------------------------------------
    tcr_baud_gen #(
        .CNT_W      (BAUD_CNT_W)
    ) u_baud (
        .clk        (clk),
        .resetn     (resetn),
        .highRate   (cfg_q[`TCR_CFG_BAUD]),
        .bitTick    (linkBitTick)
    );

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign type1OndemandSize  = odOctets(seq_q[`TCR_SEQ_T1_HI:`TCR_SEQ_T1_LO], 1'b1);
    assign type1Legacy        = (seq_q[`TCR_SEQ_T1_HI:`TCR_SEQ_T1_LO] == TCR_OD_CODE0);
    assign type1Reserved      = (seq_q[`TCR_SEQ_T1_HI:`TCR_SEQ_T1_LO] == TCR_OD_RSVD);
    assign type2OndemandSize  = odOctets(seq_q[`TCR_SEQ_T2_HI:`TCR_SEQ_T2_LO], 1'b0);
    assign type2Reserved      = (seq_q[`TCR_SEQ_T2_HI:`TCR_SEQ_T2_LO] == TCR_OD_RSVD);
    assign expectedReadOctets = seq_q[`TCR_SEQ_CNT_HI:`TCR_SEQ_CNT_LO];

    assign undervoltageThreshold     = cfg_q[`TCR_CFG_UV_HI:`TCR_CFG_UV_LO];
    assign baudSelect                = cfg_q[`TCR_CFG_BAUD];
    assign comparatorReferenceSelect = cfg_q[`TCR_CFG_REF];
    assign auxRegulatorPowerdown     = cfg_q[`TCR_CFG_AUXOFF];

    assign transparentUartMode         = pctl_q[`TCR_CTL_TOP];
    assign primaryOvercurrentThreshold = pctl_q[`TCR_CTL_OC_HI:`TCR_CTL_OC_LO];
    assign singleOctetUartMode         = pctl_q[`TCR_CTL_MODE3];
    assign standardIoModeRequest       = pctl_q[`TCR_CTL_MODE2];
    assign primaryHighSideSwitchEnable = pctl_q[`TCR_CTL_HIGH_SW];
    assign primaryLowSideSwitchEnable  = pctl_q[`TCR_CTL_LOW_SW];

    assign auxControlPinEnable           = sctl_q[`TCR_CTL_TOP];
    assign secondaryOvercurrentThreshold = sctl_q[`TCR_CTL_OC_HI:`TCR_CTL_OC_LO];
    assign levelChangeIrqEnable          = sctl_q[`TCR_CTL_MODE3];
    assign digitalIoModeRequest          = sctl_q[`TCR_CTL_MODE2];
    assign secondaryHighSideSwitchEnable = sctl_q[`TCR_CTL_HIGH_SW];
    assign secondaryLowSideSwitchEnable  = sctl_q[`TCR_CTL_LOW_SW];

    assign levelChangeIrq       = irq_q;
    assign declineResponse      = decline_q;
    assign sendResponseNow      = send_q;
    assign bufferFillCountLoad  = cntLoad_q;
    assign bufferFillCountValue = cntValue_q;

endmodule : tcr_config_regs

// File: rtl/tcr_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCR_ADDR_SEQ        7'h00
`define TCR_ADDR_CFG        7'h01
`define TCR_ADDR_PCTL       7'h02
`define TCR_ADDR_SCTL       7'h03
`define TCR_ADDR_LINK       7'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCR_SEQ_T1_HI       7
`define TCR_SEQ_T1_LO       6
`define TCR_SEQ_CNT_HI      5
`define TCR_SEQ_CNT_LO      2
`define TCR_SEQ_T2_HI       1
`define TCR_SEQ_T2_LO       0
`define TCR_CFG_UV_HI       7
`define TCR_CFG_UV_LO       5
`define TCR_CFG_BAUD        4
`define TCR_CFG_REF         3
`define TCR_CFG_AUXOFF      2
`define TCR_CTL_TOP         7
`define TCR_CTL_OC_HI       6
`define TCR_CTL_OC_LO       4
`define TCR_CTL_MODE3       3
`define TCR_CTL_MODE2       2
`define TCR_CTL_HIGH_SW     1
`define TCR_CTL_LOW_SW      0
`define TCR_LINK_CNT_HI     5
`define TCR_LINK_CNT_LO     2
`define TCR_LINK_DECLINE    1
`define TCR_LINK_SEND       0

// ----------------------------------------
// Reset values and read masks
// ----------------------------------------
`define TCR_RST_SEQ         8'h00
`define TCR_RST_CFG         8'h00
`define TCR_RST_PCTL        8'h00
`define TCR_RST_SCTL        8'h00
`define TCR_CFG_RD_MASK     8'hFC

// ----------------------------------------
// Timing
// ----------------------------------------
`define TCR_CLK_HZ          10000000
`define TCR_BAUD_HIGH       230400
`define TCR_BAUD_LOW        38400
`define TCR_BIT_CYC_HIGH    (`TCR_CLK_HZ / `TCR_BAUD_HIGH)
`define TCR_BIT_CYC_LOW     (`TCR_CLK_HZ / `TCR_BAUD_LOW)

`endif

// File: rtl/tcr_pkg.sv
// Types shared by the transceiver configuration registers
package tcr_pkg;

    typedef logic [7:0] tcr_byte_t;
    typedef logic [6:0] tcr_addr_t;

    // On-demand size codes as held in the sequence register
    typedef enum logic [1:0] {
        TCR_OD_CODE0 = 2'h0,
        TCR_OD_CODE1 = 2'h1,
        TCR_OD_CODE2 = 2'h2,
        TCR_OD_RSVD  = 2'h3
    } tcr_od_e;

endpackage : tcr_pkg

// File: rtl/tcr_spi_slave.sv
// Serial peripheral interface slave: header byte then data byte
`timescale 1ns/1ps
`include "tcr_defines.svh"

module tcr_spi_slave
    import tcr_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   spiCsN,
    input  wire logic   spiSclk,
    input  wire logic   spiMosi,
    output logic        spiMiso,
    output logic        spiMisoOe,
    input  tcr_byte_t   txByte,
    output logic        hdrValid,
    output tcr_byte_t   hdrByte,
    output logic        dataValid,
    output tcr_byte_t   dataByte
);

    if (DATA_W != 8) begin : g_chk
        $error("Only 8-bit frames are served");
    end

    logic       sclkPrev_q;
    logic [4:0] bitCnt_q;
    tcr_byte_t  rxShift_q;
    tcr_byte_t  txShift_q;
    tcr_byte_t  hdr_q;
    tcr_byte_t  data_q;
    logic       hdrValid_q;
    logic       dataValid_q;
    logic       rise;
    logic       fall;
    logic       active;
    tcr_byte_t  rxNext;

    // Sclk must stay at least two clk periods per phase
    assign active = !spiCsN;
    assign rise   = active && spiSclk && !sclkPrev_q;
    assign fall   = active && !spiSclk && sclkPrev_q;
    assign rxNext = {rxShift_q[6:0], spiMosi};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkPrev_q  <= 1'b0;
            bitCnt_q    <= '0;
            rxShift_q   <= '0;
            txShift_q   <= '0;
            hdr_q       <= '0;
            data_q      <= '0;
            hdrValid_q  <= 1'b0;
            dataValid_q <= 1'b0;
        end else begin
            sclkPrev_q  <= spiSclk;
            hdrValid_q  <= 1'b0;
            dataValid_q <= 1'b0;
            if (!active) begin
                bitCnt_q <= '0;
            end else if (rise && bitCnt_q < 5'd16) begin
                rxShift_q <= rxNext;
                bitCnt_q  <= bitCnt_q + 5'd1;
                if (bitCnt_q == 5'd7) begin
                    hdr_q      <= rxNext;
                    hdrValid_q <= 1'b1;
                end
                if (bitCnt_q == 5'd15) begin
                    data_q      <= rxNext;
                    dataValid_q <= 1'b1;
                end
            end
            // Load read data right after the header; shift on later falls
            if (hdrValid_q) begin
                txShift_q <= txByte;
            end else if (fall && bitCnt_q > 5'd8) begin
                txShift_q <= {txShift_q[6:0], 1'b0};
            end
        end
    end

    assign spiMiso   = txShift_q[7];
    assign spiMisoOe = active;
    assign hdrValid  = hdrValid_q;
    assign hdrByte   = hdr_q;
    assign dataValid = dataValid_q;
    assign dataByte  = data_q;

endmodule : tcr_spi_slave

// File: testbench/tb_transceiver_config_registers.sv
// Self-checking bench for the configuration registers
`timescale 1ns/1ps

module tb_transceiver_config_registers;
    logic       clk, resetn, secondaryLine, spiCsN, spiSclk, spiMosi, spiMiso;
    logic       type1Legacy, type1Reserved, type2Reserved, baudSelect, linkBitTick, refSel, pdReg;
    logic       xpar, oct1, stdIo, pHi, pLo, pinEn, irqEn, dig, sHi, sLo, levelChangeIrq, fillLoad, decl, sendP;
    logic [3:0] bufferFillCount, t1Size, t2Size, expOct, fillVal;
    logic [2:0] uvl, pOc, sOc;
    int         mismatches, n_tests, cycles, nLoad, nDecl, nSend, nIrq;
    wire [7:0]  cfgOut  = {uvl, baudSelect, refSel, pdReg, 2'b00};
    wire [7:0]  pctlOut = {xpar, pOc, oct1, stdIo, pHi, pLo};
    wire [7:0]  sctlOut = {pinEn, sOc, irqEn, dig, sHi, sLo};

    tcr_config_regs i_dut (
        .clk(clk), .resetn(resetn), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOe(), .type1OndemandSize(t1Size), .type1Legacy(type1Legacy), .type1Reserved(type1Reserved),
        .type2OndemandSize(t2Size), .type2Reserved(type2Reserved), .expectedReadOctets(expOct),
        .undervoltageThreshold(uvl), .baudSelect(baudSelect), .linkBitTick(linkBitTick),
        .comparatorReferenceSelect(refSel), .auxRegulatorPowerdown(pdReg), .transparentUartMode(xpar),
        .singleOctetUartMode(oct1), .standardIoModeRequest(stdIo), .primaryOvercurrentThreshold(pOc),
        .primaryHighSideSwitchEnable(pHi), .primaryLowSideSwitchEnable(pLo), .auxControlPinEnable(pinEn),
        .levelChangeIrqEnable(irqEn), .digitalIoModeRequest(dig), .secondaryOvercurrentThreshold(sOc),
        .secondaryHighSideSwitchEnable(sHi), .secondaryLowSideSwitchEnable(sLo), .secondaryLine(secondaryLine),
        .levelChangeIrq(levelChangeIrq), .bufferFillCount(bufferFillCount), .bufferFillCountLoad(fillLoad),
        .bufferFillCountValue(fillVal), .declineResponse(decl), .sendResponseNow(sendP));

    tcr_host_model i_host (.clk(clk), .spiMiso(spiMiso), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // Pulse counters and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        nLoad += (fillLoad === 1'b1);
        nDecl += (decl === 1'b1);
        nSend += (sendP === 1'b1);
        nIrq  += (levelChangeIrq === 1'b1);
        if (cycles == 40000) begin
            mismatches++;
            final_report();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer({1'b1, a, d}, 16, r);
    endtask : wr

    task automatic rdc(input string what, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        i_host.xfer({1'b0, a, 8'h00}, 16, r);
        chk(what, exp, r);
    endtask : rdc

    task automatic do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        chk("t2 size", 8'h01, {4'h0, t2Size});
        chk("t1 legacy", 8'h01, {7'h00, type1Legacy});
        for (int a = 0; a < 4; a++) rdc("reset value", a[6:0], 8'h00);
        rdc("link read", 7'h04, 8'h28);
    endtask : test_reset

    task automatic test_message_sequence_config;
        logic [3:0] t1 [4] = '{4'h0, 4'h2, 4'h8, 4'h0};
        logic [3:0] t2 [4] = '{4'h1, 4'h2, 4'h8, 4'h0};
        for (int c = 0; c < 4; c++) begin
            wr(7'h00, {c[1:0], 4'hC - c[3:0], c[1:0]});
            chk("t1 decode", {t1[c], c == 0, c == 3, 2'b00}, {t1Size, type1Legacy, type1Reserved, 2'b00});
            chk("t2 decode", {t2[c], 3'b000, c == 3}, {t2Size, 3'b000, type2Reserved});
            chk("read octets", {4'h0, 4'hC - c[3:0]}, {4'h0, expOct});
        end
    endtask : test_message_sequence_config

    task automatic test_cfg;
        logic [7:0] v [3] = '{8'hFF, 8'hA8, 8'h54};
        foreach (v[i]) begin
            wr(7'h01, v[i]);
            chk("cfg fields", v[i] & 8'hFC, cfgOut);
            rdc("cfg read", 7'h01, v[i] & 8'hFC);
            repeat (600) @(posedge clk);
        end
    endtask : test_cfg

    task automatic test_ctl;
        logic [7:0] v [2] = '{8'hA5, 8'h5A};
        foreach (v[i]) begin
            wr(7'h02, v[i]);
            wr(7'h03, ~v[i]);
            chk("primary fields", v[i], pctlOut);
            chk("secondary fields", ~v[i], sctlOut);
            rdc("primary read", 7'h02, v[i]);
            rdc("secondary read", 7'h03, ~v[i]);
        end
    endtask : test_ctl

    task automatic test_link;
        int l0 = nLoad;
        int d0 = nDecl;
        int s0 = nSend;
        wr(7'h04, 8'h3B);
        chk("pulses", {2'b00, 2'(nLoad - l0), 2'(nDecl - d0), 2'(nSend - s0)}, 8'h15);
        chk("fill value", 8'h0E, {4'h0, fillVal});
        wr(7'h04, 8'h01);
        chk("pulses", {2'b00, 2'(nLoad - l0), 2'(nDecl - d0), 2'(nSend - s0)}, 8'h26);
        rdc("link read", 7'h04, 8'h28);
    endtask : test_link

    task automatic test_refuse;
        logic [7:0] r;
        wr(7'h01, 8'h54);
        i_host.xfer({1'b1, 7'h01, 8'hFF}, 12, r);
        rdc("aborted write", 7'h01, 8'h54);
        wr(7'h7F, 8'hFF);
        rdc("unmapped read", 7'h7F, 8'h00);
        rdc("cfg intact", 7'h01, 8'h54);
        do_reset();
        chk("cfg after reset", 8'h00, cfgOut);
    endtask : test_refuse

    task automatic test_irq;
        int b = nIrq;
        for (int en = 0; en < 2; en++) begin
            wr(7'h03, en ? 8'h08 : 8'h00);
            repeat (2) begin
                secondaryLine <= ~secondaryLine;
                repeat (4) @(posedge clk);
            end
        end
        chk("irq pulses", 8'h02, 8'(nIrq - b));
    endtask : test_irq

    initial begin
        resetn          = 1'b0;
        secondaryLine   = 1'b0;
        bufferFillCount = 4'hA;
        do_reset();
        test_reset();
        test_message_sequence_config();
        test_cfg();
        test_ctl();
        test_link();
        test_refuse();
        test_irq();
        final_report();
    end
endmodule : tb_transceiver_config_registers

// File: testbench/tcr_config_regs_assertions.sv
// Concurrent checks on the register block ports
`timescale 1ns/1ps
`include "tcr_defines.svh"

module tcr_config_regs_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       spiCsN,
    input wire logic       spiSclk,
    input wire logic [3:0] type1OndemandSize,
    input wire logic       type1Legacy,
    input wire logic       type1Reserved,
    input wire logic [3:0] type2OndemandSize,
    input wire logic       type2Reserved,
    input wire logic [3:0] expectedReadOctets,
    input wire logic [2:0] undervoltageThreshold,
    input wire logic       baudSelect,
    input wire logic       linkBitTick,
    input wire logic       comparatorReferenceSelect,
    input wire logic       auxRegulatorPowerdown,
    input wire logic       secondaryLine,
    input wire logic       levelChangeIrqEnable,
    input wire logic       levelChangeIrq,
    input wire logic       bufferFillCountLoad,
    input wire logic       declineResponse,
    input wire logic       sendResponseNow
);
    // -------------------------------------------
    // Tick spacing tracker
    // -------------------------------------------
    logic [11:0] tickGap_q;
    logic        tickSeen_q;
    logic        baudChg_q;
    logic        baud_q;

    // A rate change leaves the divider count running, so that gap is not judged
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tickGap_q  <= 12'h000;
            tickSeen_q <= 1'b0;
            baudChg_q  <= 1'b0;
            baud_q     <= 1'b0;
        end else begin
            baud_q <= baudSelect;
            if (linkBitTick) begin
                tickGap_q  <= 12'h000;
                tickSeen_q <= 1'b1;
                baudChg_q  <= 1'b0;
            end else begin
                tickGap_q <= tickGap_q + 12'h001;
                if (baudSelect != baud_q) begin
                    baudChg_q <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // -------------------------------------------
    // Assertions
    // -------------------------------------------
    type1_decode_a: assert property ((type1Legacy || type1Reserved)
        ? (type1OndemandSize == 4'h0 && !(type1Legacy && type1Reserved)) : (type1OndemandSize inside {4'h2, 4'h8}))
        else $error("type-1 size decode inconsistent");
    type2_decode_a: assert property (type2Reserved ? type2OndemandSize == 4'h0
        : (type2OndemandSize inside {4'h1, 4'h2, 4'h8}))
        else $error("type-2 size decode inconsistent");
    irq_follow_a: assert property (levelChangeIrq ==
        ($past(levelChangeIrqEnable) && ($past(secondaryLine) != $past(secondaryLine, 2))))
        else $error("level change pulse does not follow line");
    decline_pulse_a: assert property (declineResponse |-> bufferFillCountLoad ##1 !declineResponse)
        else $error("decline pulse malformed");
    send_pulse_a: assert property (sendResponseNow |-> bufferFillCountLoad ##1 !sendResponseNow)
        else $error("send pulse malformed");
    load_cause_a: assert property (bufferFillCountLoad |->
        ($past(spiSclk, 2) && !$past(spiCsN, 2)) ##1 !bufferFillCountLoad)
        else $error("link load without a bus write");
    cfg_hold_a: assert property ((spiCsN && $past(spiCsN) && $past(spiCsN, 2) && $past(spiCsN, 3))
        |-> $stable({undervoltageThreshold, baudSelect, comparatorReferenceSelect, auxRegulatorPowerdown,
        expectedReadOctets}))
        else $error("config fields changed while idle");
    tick_period_a: assert property ((linkBitTick && tickSeen_q && !baudChg_q && baudSelect == baud_q)
        |-> tickGap_q == (baudSelect ? `TCR_BIT_CYC_HIGH - 1 : `TCR_BIT_CYC_LOW - 1))
        else $error("bit tick spacing wrong");
endmodule : tcr_config_regs_checker

bind tcr_config_regs tcr_config_regs_checker i_chk (
    .clk(clk), .resetn(resetn), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .type1OndemandSize(type1OndemandSize), .type1Legacy(type1Legacy), .type1Reserved(type1Reserved),
    .type2OndemandSize(type2OndemandSize), .type2Reserved(type2Reserved), .expectedReadOctets(expectedReadOctets),
    .undervoltageThreshold(undervoltageThreshold), .baudSelect(baudSelect), .linkBitTick(linkBitTick),
    .comparatorReferenceSelect(comparatorReferenceSelect), .auxRegulatorPowerdown(auxRegulatorPowerdown),
    .secondaryLine(secondaryLine), .levelChangeIrqEnable(levelChangeIrqEnable), .levelChangeIrq(levelChangeIrq),
    .bufferFillCountLoad(bufferFillCountLoad), .declineResponse(declineResponse), .sendResponseNow(sendResponseNow)
);

// File: testbench/tcr_host_model.sv
// Host-side serial peripheral interface master, mode 0
`timescale 1ns/1ps

module tcr_host_model (
    input  wire logic clk,
    input  wire logic spiMiso,
    output logic      spiCsN,
    output logic      spiSclk,
    output logic      spiMosi
);
    initial begin
        spiCsN  = 1'b1;
        spiSclk = 1'b0;
        spiMosi = 1'b0;
    end

    // Four clk per phase; fewer bits than 16 gives an aborted frame
    task automatic xfer(input logic [15:0] frame, input int nBits, output logic [7:0] rdData);
        rdData = 8'h00;
        @(posedge clk);
        spiCsN <= 1'b0;
        for (int i = 0; i < nBits; i++) begin
            @(posedge clk);
            spiMosi <= frame[15 - i];
            repeat (3) @(posedge clk);
            if (i >= 8) begin
                rdData = {rdData[6:0], spiMiso};
            end
            spiSclk <= 1'b1;
            repeat (4) @(posedge clk);
            spiSclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        spiCsN  <= 1'b1;
        // Released data line must not keep its last bit
        spiMosi <= ~spiMosi;
        repeat (2) @(posedge clk);
    endtask : xfer
endmodule : tcr_host_model
